/* verilog/pec_counters.sv */
// Two performance event counters with selectors and register port
`timescale 1ns/1ps
// Contract
// [RULE_01] Selector low byte picks the event the paired counter accumulates.
// [RULE_02] Bits 15:8 qualify the event; zero allows all options where unqualified.
// [RULE_03] Bit 16 counts events at privilege levels one to three.
// [RULE_04] Bit 17 counts events at privilege level zero.
// [RULE_05] Bit 18 one counts occurrences, zero counts cycles the event holds; with bit 18 zero and a zero threshold the code adds the per-cycle event count.
// [RULE_06] Bit 19 signals counter overflow on breakpoint pin zero.
// [RULE_07] Bit 20 sends counter overflow to the local interrupt controller.
// [RULE_08] Bit 22 of selector zero enables both counters.
// [RULE_09] Bit 23 inverts the threshold comparison.
// [RULE_10] Nonzero threshold: advance one when per-cycle count meets it.
// [RULE_11] L2 events: low qualifier bits pick M, E, S, I states, combined.
// [RULE_12] L2 state qualifier of zero counts nothing.
// [RULE_13] Bus events: qualifier bit 5 chooses self or any processor.
// [RULE_14] Software puts float-executed and divider-busy only on counter zero.
// [RULE_15] Software puts float assist, multiply and divide only on counter one.
// [RULE_16] Code 79 counts every cycle the core is not halted.
// [RULE_17] Codes C6, C7, C8 count masked, masked-pending cycles and interrupts.
// [RULE_18] Codes C0, C2, C4 count retired instructions, micro-ops, branches.
// [RULE_19] Codes C5, C9, CA count mispredicted, taken, taken-mispredicted branches.
// [RULE_20] Codes E0, E2, E6 count decoded branches, target misses, redirects.
// [RULE_21] Codes 03, 04, 05 count store blocks, drain cycles, misaligned refs.
// [RULE_22] Codes D0, D2, 06 count decodes, partial alias stalls, segment loads.
// [RULE_23] Code A2 counts resource stall cycles.
module pec_counters (
  input  wire logic        core_clk_in,                // Core clock, 100 MHz
  input  wire logic        rstn_in,                    // Sync reset, active low
  input  wire logic        msr_rd_in,                  // Register read strobe
  input  wire logic        msr_wr_in,                  // Register write strobe
  input  wire logic [31:0] msr_addr_in,                // Register address
  input  wire logic [63:0] msr_wdata_in,               // Register write data
  input  wire logic [1:0]  cpl_in,                     // Current privilege level
  input  wire logic        halted_in,                  // Core halted
  input  wire logic        int_masked_in,              // Interrupts disabled
  input  wire logic        int_pending_in,             // Interrupt pending
  input  wire logic        hardware_irq_received_in,   // Interrupt taken
  input  wire logic [1:0]  instructions_retired_in,    // Retired this cycle
  input  wire logic [1:0]  microops_retired_in,        // Retired this cycle
  input  wire logic        br_retired_in,              // Branch retired
  input  wire logic        br_misp_retired_in,         // Mispredicted retired
  input  wire logic        br_taken_retired_in,        // Taken retired
  input  wire logic        br_taken_misp_retired_in,   // Taken mispredicted retired
  input  wire logic        br_decoded_in,              // Branch decoded
  input  wire logic        btb_miss_in,                // Target buffer miss
  input  wire logic        frontend_redirect_in,       // Redirect asserted
  input  wire logic        store_buf_block_in,         // Store buffer block
  input  wire logic        store_buf_drain_in,         // Store buffer draining
  input  wire logic        misalign_ref_in,            // Misaligned reference
  input  wire logic [1:0]  inst_decoded_in,            // Decoded this cycle
  input  wire logic        partial_alias_stalls_in,    // Partial alias stall
  input  wire logic        seg_load_in,                // Segment register load
  input  wire logic        resource_stall_in,          // Resource stall
  input  wire logic        float_ops_executed_in,      // Float op executed
  input  wire logic        float_microcode_assists_in, // Float assist
  input  wire logic        mul_in,                     // Multiply
  input  wire logic        div_in,                     // Divide
  input  wire logic        div_busy_in,                // Divider busy
  input  wire logic        l2_ifetch_in,               // L2 fetch access
  input  wire logic        l2_load_in,                 // L2 load access
  input  wire logic        l2_store_in,                // L2 store access
  input  wire logic [3:0]  l2_state_in,                // One-hot line state M,E,S,I
  input  wire logic        bus_tran_self_in,           // Own bus transaction
  input  wire logic        bus_tran_any_in,            // Any agent's transaction
  output logic      [63:0] msr_rdata_out,              // Read data
  output logic             msr_ack_out,                // Access done pulse
  output logic             msr_fault_out,              // Unmapped address pulse
  output logic             breakpoint_pin_zero_out,    // Overflow on pin
  output logic             local_irq_controller_out    // Overflow to interrupt controller
);
  // ****************************************
  // Register port
  // ****************************************
  logic [31:0] sel_reg  [pec_pkg::LANES];
  logic [31:0] sel_next [pec_pkg::LANES];
  logic [63:0] count    [pec_pkg::LANES];
  logic [1:0]  raw      [pec_pkg::LANES];
  logic        ctr_wr   [pec_pkg::LANES];
  logic        ovf      [pec_pkg::LANES];
  logic [63:0] rdata_reg;
  logic [63:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;
  logic        fault_reg;
  logic        fault_next;
  logic        pin_reg;
  logic        pin_next;
  logic        irq_reg;
  logic        irq_next;
  logic        hit_sel0;
  logic        hit_sel1;
  logic        hit_ctr0;
  logic        hit_ctr1;
  logic        access;

  always_comb begin
    hit_ctr0   = (msr_addr_in == pec_pkg::ADDR_COUNTER_ZERO);
    hit_ctr1   = (msr_addr_in == pec_pkg::ADDR_COUNTER_ONE);
    hit_sel0   = (msr_addr_in == pec_pkg::ADDR_SELECTOR_ZERO);
    hit_sel1   = (msr_addr_in == pec_pkg::ADDR_SELECTOR_ONE);
    access     = msr_rd_in || msr_wr_in;
    ack_next   = access;
    fault_next = access && !(hit_ctr0 || hit_ctr1 || hit_sel0 || hit_sel1);
    ctr_wr[0]  = msr_wr_in && hit_ctr0;
    ctr_wr[1]  = msr_wr_in && hit_ctr1;
    sel_next[0] = (msr_wr_in && hit_sel0) ? msr_wdata_in[31:0] : sel_reg[0];
    sel_next[1] = (msr_wr_in && hit_sel1) ? msr_wdata_in[31:0] : sel_reg[1];
    rdata_next = rdata_reg;
    if (msr_rd_in) begin
      case (1'b1)
        hit_ctr0: rdata_next = count[0];
        hit_ctr1: rdata_next = count[1];
        hit_sel0: rdata_next = {32'h0, sel_reg[0]};
        hit_sel1: rdata_next = {32'h0, sel_reg[1]};
        default:  rdata_next = 64'h0;
      endcase
    end
    // Overflow leaves one cycle after the counter wraps
    pin_next = (ovf[0] && sel_reg[0][pec_pkg::PIN_BIT])   // RULE_06
            || (ovf[1] && sel_reg[1][pec_pkg::PIN_BIT]);
    irq_next = (ovf[0] && sel_reg[0][pec_pkg::IRQ_BIT])   // RULE_07
            || (ovf[1] && sel_reg[1][pec_pkg::IRQ_BIT]);
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sel_reg[0] <= pec_pkg::SELECTOR_RESET;
      sel_reg[1] <= pec_pkg::SELECTOR_RESET;
      rdata_reg  <= 64'h0;
      ack_reg    <= 1'b0;
      fault_reg  <= 1'b0;
      pin_reg    <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      sel_reg[0] <= sel_next[0];
      sel_reg[1] <= sel_next[1];
      rdata_reg  <= rdata_next;
      ack_reg    <= ack_next;
      fault_reg  <= fault_next;
      pin_reg    <= pin_next;
      irq_reg    <= irq_next;
    end
  end

  assign msr_rdata_out            = rdata_reg;
  assign msr_ack_out              = ack_reg;
  assign msr_fault_out            = fault_reg;
  assign breakpoint_pin_zero_out  = pin_reg;
  assign local_irq_controller_out = irq_reg;

  // ****************************************
  // Event selection per counter
  // ****************************************
  for (genvar g = 0; g < pec_pkg::LANES; g++) begin : g_lane
    logic [7:0] code;
    logic [7:0] qual;
    logic       l2_hit;

    always_comb begin
      code   = sel_reg[g][pec_pkg::CODE_MSB:pec_pkg::CODE_LSB];  // RULE_01
      qual   = sel_reg[g][pec_pkg::QUAL_MSB:pec_pkg::QUAL_LSB];  // RULE_02
      // Zero state mask matches no line state
      l2_hit = ((l2_state_in & qual[3:0]) != 4'h0);  // RULE_11 RULE_12
      case (code)
        pec_pkg::EV_UNHALTED:      raw[g] = {1'b0, !halted_in};  // RULE_16
        pec_pkg::EV_INT_MASKED:    raw[g] = {1'b0, int_masked_in};  // RULE_17
        pec_pkg::EV_INT_MASK_PEND: raw[g] = {1'b0, int_masked_in && int_pending_in};  // RULE_17
        pec_pkg::EV_HW_IRQ:        raw[g] = {1'b0, hardware_irq_received_in};  // RULE_17
        pec_pkg::EV_INST_RET:      raw[g] = instructions_retired_in;  // RULE_18
        pec_pkg::EV_UOP_RET:       raw[g] = microops_retired_in;  // RULE_18
        pec_pkg::EV_BR_RET:        raw[g] = {1'b0, br_retired_in};  // RULE_18
        pec_pkg::EV_BR_MISP_RET:   raw[g] = {1'b0, br_misp_retired_in};  // RULE_19
        pec_pkg::EV_BR_TAKEN_RET:  raw[g] = {1'b0, br_taken_retired_in};  // RULE_19
        pec_pkg::EV_BR_TK_MISP:    raw[g] = {1'b0, br_taken_misp_retired_in};  // RULE_19
        pec_pkg::EV_BR_DEC:        raw[g] = {1'b0, br_decoded_in};  // RULE_20
        pec_pkg::EV_BTB_MISS:      raw[g] = {1'b0, btb_miss_in};  // RULE_20
        pec_pkg::EV_REDIRECT:      raw[g] = {1'b0, frontend_redirect_in};  // RULE_20
        pec_pkg::EV_SB_BLOCK:      raw[g] = {1'b0, store_buf_block_in};  // RULE_21
        pec_pkg::EV_SB_DRAIN:      raw[g] = {1'b0, store_buf_drain_in};  // RULE_21
        pec_pkg::EV_MISALIGN:      raw[g] = {1'b0, misalign_ref_in};  // RULE_21
        pec_pkg::EV_INST_DEC:      raw[g] = inst_decoded_in;  // RULE_22
        pec_pkg::EV_ALIAS_STALL:   raw[g] = {1'b0, partial_alias_stalls_in};  // RULE_22
        pec_pkg::EV_SEG_LOAD:      raw[g] = {1'b0, seg_load_in};  // RULE_22
        pec_pkg::EV_RES_STALL:     raw[g] = {1'b0, resource_stall_in};  // RULE_23
        // Unsupported lane reads zero so a misprogrammed selector stays quiet
        pec_pkg::EV_FP_EXEC:       raw[g] = {1'b0, (g == 0) && float_ops_executed_in};  // RULE_14
        pec_pkg::EV_DIV_BUSY:      raw[g] = {1'b0, (g == 0) && div_busy_in};  // RULE_14
        pec_pkg::EV_FLOAT_MICROCODE_ASSISTS:     raw[g] = {1'b0, (g == 1) && float_microcode_assists_in};  // RULE_15
        pec_pkg::EV_MUL:           raw[g] = {1'b0, (g == 1) && mul_in};  // RULE_15
        pec_pkg::EV_DIV:           raw[g] = {1'b0, (g == 1) && div_in};  // RULE_15
        pec_pkg::EV_L2_IFETCH:     raw[g] = {1'b0, l2_ifetch_in && l2_hit};  // RULE_11
        pec_pkg::EV_L2_LD:         raw[g] = {1'b0, l2_load_in && l2_hit};  // RULE_11
        pec_pkg::EV_L2_ST:         raw[g] = {1'b0, l2_store_in && l2_hit};  // RULE_11
        pec_pkg::EV_L2_RQST:       raw[g] = {1'b0, (l2_ifetch_in || l2_load_in || l2_store_in) && l2_hit};
        pec_pkg::EV_BUS_TRAN_ANY:  raw[g] = {1'b0, qual[pec_pkg::QUAL_ANY_BIT] ? bus_tran_any_in  // RULE_13
                                                                                : bus_tran_self_in};
        default:                   raw[g] = 2'h0;
      endcase
    end

    pec_counter_lane u_lane (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .sel_in      (sel_reg[g]),
      .gen_en_in   (sel_reg[0][pec_pkg::GEN_BIT]),  // RULE_08
      .cpl_in      (cpl_in),
      .raw_in      (raw[g]),
      .wr_in       (ctr_wr[g]),
      .wdata_in    (msr_wdata_in),
      .count_out   (count[g]),
      .ovf_out     (ovf[g])
    );
  end

  // ****************************************
  // Checks
  // ****************************************
  a_pin_overflow: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_06
    (ovf[0] && sel_reg[0][pec_pkg::PIN_BIT]) |=> breakpoint_pin_zero_out)
    else $error("Overflow did not reach the pin");
  a_irq_overflow: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_07
    breakpoint_pin_zero_out || local_irq_controller_out |-> $past(ovf[0] || ovf[1]))
    else $error("Overflow signal without a wrap");
  a_irq_reach: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_07
    (ovf[0] && sel_reg[0][pec_pkg::IRQ_BIT]) |=> local_irq_controller_out)
    else $error("Overflow did not reach the interrupt controller");
  a_lane_exclusive: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_14
    (sel_reg[1][7:0] == pec_pkg::EV_FP_EXEC || sel_reg[1][7:0] == pec_pkg::EV_DIV_BUSY) |-> raw[1] == 2'h0)
    else $error("Second counter saw a first-counter-only event");
  a_state_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_12
    (sel_reg[0][7:0] == pec_pkg::EV_L2_LD && sel_reg[0][11:8] == 4'h0) |-> raw[0] == 2'h0)
    else $error("Zero state mask still counted");
  a_unhalted: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_16
    (sel_reg[0][7:0] == pec_pkg::EV_UNHALTED) |-> raw[0] == {1'b0, !halted_in})
    else $error("Unhalted event wrong");
  a_sel_readback: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_01
    (msr_wr_in && hit_sel1) ##1 !msr_wr_in ##1 (msr_rd_in && hit_sel1 && !msr_wr_in)
    |=> msr_rdata_out[31:0] == $past(msr_wdata_in[31:0], 3) && msr_ack_out) else $error("Selector readback wrong");
endmodule

/* verilog/pec_pkg.sv */
// Constants shared by the performance event counter block
package pec_pkg;
  // ****************************************
  // Register addresses and widths
  // ****************************************
  localparam logic [31:0] ADDR_COUNTER_ZERO  = 32'h0000_00c1;
  localparam logic [31:0] ADDR_COUNTER_ONE   = 32'h0000_00c2;
  localparam logic [31:0] ADDR_SELECTOR_ZERO = 32'h0000_0186;
  localparam logic [31:0] ADDR_SELECTOR_ONE  = 32'h0000_0187;
  localparam int          CNT_W              = 64;
  localparam int          SEL_W              = 32;
  localparam int          LANES              = 2;
  localparam logic [63:0] COUNTER_RESET      = 64'h0;
  localparam logic [31:0] SELECTOR_RESET     = 32'h0;

  // ****************************************
  // Selector field positions
  // ****************************************
  localparam int CODE_LSB  = 0;
  localparam int CODE_MSB  = 7;
  localparam int QUAL_LSB  = 8;
  localparam int QUAL_MSB  = 15;
  localparam int USR_BIT   = 16;
  localparam int KERN_BIT  = 17;
  localparam int EDGE_BIT  = 18;
  localparam int PIN_BIT   = 19;
  localparam int IRQ_BIT   = 20;
  localparam int GEN_BIT   = 22;
  localparam int NEG_BIT   = 23;
  localparam int THR_LSB   = 24;
  localparam int THR_MSB   = 31;
  localparam int QUAL_ANY_BIT = 5;

  // ****************************************
  // Event codes
  // ****************************************
  localparam logic [7:0] EV_FP_EXEC       = 8'h10;
  localparam logic [7:0] EV_FLOAT_MICROCODE_ASSISTS     = 8'h11;
  localparam logic [7:0] EV_MUL           = 8'h12;
  localparam logic [7:0] EV_DIV           = 8'h13;
  localparam logic [7:0] EV_DIV_BUSY      = 8'h14;
  localparam logic [7:0] EV_SB_BLOCK      = 8'h03;
  localparam logic [7:0] EV_SB_DRAIN      = 8'h04;
  localparam logic [7:0] EV_MISALIGN      = 8'h05;
  localparam logic [7:0] EV_SEG_LOAD      = 8'h06;
  localparam logic [7:0] EV_INST_RET      = 8'hc0;
  localparam logic [7:0] EV_UOP_RET       = 8'hc2;
  localparam logic [7:0] EV_BR_RET        = 8'hc4;
  localparam logic [7:0] EV_BR_MISP_RET   = 8'hc5;
  localparam logic [7:0] EV_INT_MASKED    = 8'hc6;
  localparam logic [7:0] EV_INT_MASK_PEND = 8'hc7;
  localparam logic [7:0] EV_HW_IRQ        = 8'hc8;
  localparam logic [7:0] EV_BR_TAKEN_RET  = 8'hc9;
  localparam logic [7:0] EV_BR_TK_MISP    = 8'hca;
  localparam logic [7:0] EV_INST_DEC      = 8'hd0;
  localparam logic [7:0] EV_ALIAS_STALL   = 8'hd2;
  localparam logic [7:0] EV_BR_DEC        = 8'he0;
  localparam logic [7:0] EV_BTB_MISS      = 8'he2;
  localparam logic [7:0] EV_REDIRECT      = 8'he6;
  localparam logic [7:0] EV_RES_STALL     = 8'ha2;
  localparam logic [7:0] EV_UNHALTED      = 8'h79;
  localparam logic [7:0] EV_L2_IFETCH     = 8'h28;
  localparam logic [7:0] EV_L2_LD         = 8'h29;
  localparam logic [7:0] EV_L2_ST         = 8'h2a;
  localparam logic [7:0] EV_L2_RQST       = 8'h2e;
  localparam logic [7:0] EV_BUS_TRAN_ANY  = 8'h70;
endpackage

/* verilog/pec_counter_lane.sv */
// One qualified event counter with mode, threshold and overflow
`timescale 1ns/1ps
module pec_counter_lane (
  input  wire logic        core_clk_in,  // Core clock
  input  wire logic        rstn_in,      // Sync reset, active low
  input  wire logic [31:0] sel_in,       // Selector contents
  input  wire logic        gen_en_in,    // Global enable
  input  wire logic [1:0]  cpl_in,       // Current privilege level
  input  wire logic [1:0]  raw_in,       // Per-cycle event count
  input  wire logic        wr_in,        // Counter write strobe
  input  wire logic [63:0] wdata_in,     // Counter write data
  output logic      [63:0] count_out,    // Counter value
  output logic             ovf_out       // Overflow pulse
);
  logic [63:0] count_reg;
  logic [63:0] count_next;
  logic        prev_reg;
  logic        prev_next;
  logic        ovf_reg;
  logic        ovf_next;
  logic        priv_ok;
  logic        active;
  logic        cond;
  logic [1:0]  inc;
  logic [7:0]  thr;
  logic [64:0] sum;

  always_comb begin
    priv_ok = (sel_in[pec_pkg::USR_BIT] && (cpl_in != 2'h0))  // RULE_03
           || (sel_in[pec_pkg::KERN_BIT] && (cpl_in == 2'h0));   // RULE_04
    active  = priv_ok && gen_en_in;                            // RULE_08
    thr     = sel_in[pec_pkg::THR_MSB:pec_pkg::THR_LSB];
    if (thr != 8'h0) begin
      cond = ({6'h0, raw_in} >= thr) ^ sel_in[pec_pkg::NEG_BIT];  // RULE_09 RULE_10
    end else begin
      cond = (raw_in != 2'h0);
    end
    if (sel_in[pec_pkg::EDGE_BIT]) begin
      inc = (cond && !prev_reg) ? 2'h1 : 2'h0;  // RULE_05
    end else if (thr != 8'h0) begin
      inc = cond ? 2'h1 : 2'h0;  // RULE_10
    end else begin
      inc = raw_in;  // RULE_05
    end
    prev_next  = cond && active;
    sum        = {1'b0, count_reg} + {63'h0, inc};
    count_next = count_reg;
    ovf_next   = 1'b0;
    // Software write wins over a same-cycle count
    if (wr_in) begin
      count_next = wdata_in;
    end else if (active && (inc != 2'h0)) begin
      count_next = sum[63:0];
      ovf_next   = sum[64];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      count_reg <= pec_pkg::COUNTER_RESET;
      prev_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      prev_reg  <= prev_next;
      ovf_reg   <= ovf_next;
    end
  end

  assign count_out = count_reg;
  assign ovf_out   = ovf_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_gen_hold: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_08
    (!gen_en_in && !wr_in) |=> $stable(count_reg)) else $error("Counted while globally disabled");
  a_kernel_block: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_04
    (cpl_in == 2'h0 && !sel_in[pec_pkg::KERN_BIT] && !wr_in) |=> $stable(count_reg))
    else $error("Counted at level zero without kernel enable");
  a_thr_step: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_10
    (!wr_in && sel_in[pec_pkg::THR_MSB:pec_pkg::THR_LSB] != 8'h0 && !ovf_next)
    |=> (count_reg - $past(count_reg)) <= 64'h1) else $error("Threshold mode stepped by more than one");
  a_dur_raw: assert property (@(posedge core_clk_in) disable iff (!rstn_in)  // RULE_05
    (!wr_in && active && !sel_in[pec_pkg::EDGE_BIT] && sel_in[pec_pkg::THR_MSB:pec_pkg::THR_LSB] == 8'h0
     && !count_reg[63]) |=> count_reg == $past(count_reg) + {62'h0, $past(raw_in)})
    else $error("Duration count did not add the raw count");
endmodule

/* tb/tb_pec_counters.sv */
// Self-checking bench for the two performance event counters
`timescale 1ns/1ps
module tb_pec_counters;
  localparam logic [31:0] C0 = pec_pkg::ADDR_COUNTER_ZERO, C1 = pec_pkg::ADDR_COUNTER_ONE;
  localparam logic [31:0] S0 = pec_pkg::ADDR_SELECTOR_ZERO, S1 = pec_pkg::ADDR_SELECTOR_ONE;
  logic        core_clk_in = 1'b0, rstn_in = 1'b0, msr_rd_in = 1'b0, msr_wr_in = 1'b0;
  logic        ev = 1'b0, halted_in = 1'b0;
  logic [1:0]  cpl_in = 2'h0, rc = 2'h0;
  logic [3:0]  l2_state_in = 4'h0;
  logic [31:0] msr_addr_in = 32'h0;
  logic [63:0] msr_wdata_in = 64'h0, msr_rdata_out;
  logic        msr_ack_out, msr_fault_out, breakpoint_pin_zero_out, local_irq_controller_out;
  int          failures = 0, tests_run = 0;
  // One driver for nearly all flags; the any-agent bus flag differs so the source choice shows
  wire [1:0] instructions_retired_in = rc, microops_retired_in = rc, inst_decoded_in = rc;
  wire int_masked_in = ev, int_pending_in = ev, hardware_irq_received_in = ev, br_retired_in = ev,
    br_misp_retired_in = ev, br_taken_retired_in = ev, br_taken_misp_retired_in = ev, br_decoded_in = ev,
    btb_miss_in = ev, frontend_redirect_in = ev, store_buf_block_in = ev, store_buf_drain_in = ev,
    misalign_ref_in = ev, partial_alias_stalls_in = ev, seg_load_in = ev, resource_stall_in = ev,
    float_ops_executed_in = ev, float_microcode_assists_in = ev, mul_in = ev, div_in = ev, div_busy_in = ev,
    l2_ifetch_in = ev, l2_load_in = ev, l2_store_in = ev, bus_tran_self_in = ev, bus_tran_any_in = rc[1];

  always #5 core_clk_in = ~core_clk_in;
  pec_counters DUT (.*);

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Register port helpers, entered at a falling edge
  // ****************************************
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
    msr_wr_in = w;
    msr_rd_in = ~w;
    msr_addr_in = a;
    msr_wdata_in = d;
    @(negedge core_clk_in);
    msr_wr_in = 1'b0;
    msr_rd_in = 1'b0;
    check({62'h0, msr_fault_out, msr_ack_out}, {62'h0, a != C0 && a != C1 && a != S0 && a != S1, 1'b1});
    // Idle cycle, so a strobe is never lowered and raised in one step
    @(negedge core_clk_in);
  endtask

  task automatic rd(input logic [31:0] a, input logic [63:0] exp);
    acc(1'b0, a, 64'h0);
    check(msr_rdata_out, exp);
  endtask

  // Counter cleared last: a write in the event cycle drops the event
  task automatic arm(input logic [31:0] s);
    acc(1'b1, S0, {32'h0, s});
    acc(1'b1, C0, 64'h0);
  endtask

  task automatic pulse(input int n);
    ev = 1'b1;
    rc = 2'h1;
    repeat (n) @(negedge core_clk_in);
    ev = 1'b0;
    rc = 2'h0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] adr [4] = '{C0, C1, S0, S1};
    foreach (adr[i]) rd(adr[i], 64'h0);
    acc(1'b1, C1, 64'hdead_beef_0123_4567);
    acc(1'b1, S1, 64'hffff_ffff_0034_5678);
    rd(S1, 64'h0000_0000_0034_5678);
    rd(C1, 64'hdead_beef_0123_4567);
    acc(1'b1, 32'h0000_0188, 64'h1);
    rd(32'h0000_0188, 64'h0);
  endtask

  task automatic t_codes;
    logic [7:0] codes [30] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'hc0, 8'hc2, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hc8,
      8'hc9, 8'hca, 8'hd0, 8'hd2, 8'he0, 8'he2, 8'he6, 8'ha2, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
      8'h28, 8'h29, 8'h2a, 8'h2e, 8'h70, 8'h78};
    logic none;
    logic [31:0] ca;
    l2_state_in = 4'h2;
    for (int l = 0; l < 2; l++) begin
      foreach (codes[i]) begin
        none = codes[i] == 8'h78 || (l == 1 ? codes[i] inside {8'h10, 8'h14} : codes[i] inside {[8'h11:8'h13]});
        ca = l == 1 ? C1 : C0;
        acc(1'b1, S0, {32'h0, l == 1 ? 32'h0040_0000 : 32'h0043_0f00 | codes[i]});
        acc(1'b1, S1, {32'h0, 32'h0003_0f00 | codes[i]});
        acc(1'b1, ca, 64'h0);
        pulse(2);
        rd(ca, none ? 64'h0 : 64'h2);
      end
    end
  endtask

  task automatic t_priv(input logic [31:0] s, input logic [1:0] off, input logic [1:0] on);
    cpl_in = off;
    arm(s);
    pulse(2);
    rd(C0, 64'h0);
    cpl_in = on;
    pulse(2);
    cpl_in = off;
    rd(C0, {62'h0, s[22], 1'b0});
  endtask

  task automatic t_thresh;
    arm(32'h0243_00c0);
    rc = 2'h3;
    @(negedge core_clk_in);
    rc = 2'h1;
    @(negedge core_clk_in);
    rc = 2'h0;
    rd(C0, 64'h1);
    rc = 2'h3;
    arm(32'h02c3_00c0);
    rd(C0, 64'h0);
    rc = 2'h1;
    repeat (2) @(negedge core_clk_in);
    rc = 2'h3;
    rd(C0, 64'h2);
    rc = 2'h0;
    arm(32'h0047_00c0);
    pulse(3);
    rd(C0, 64'h1);
  endtask

  task automatic t_ovf(input logic [31:0] s);
    int pin = 0;
    int irq = 0;
    acc(1'b1, S0, {32'h0, s});
    acc(1'b1, C0, 64'hffff_ffff_ffff_ffff);
    pulse(1);
    repeat (4) begin
      pin += breakpoint_pin_zero_out;
      irq += local_irq_controller_out;
      @(negedge core_clk_in);
    end
    check(64'(pin), {63'h0, s[19]});
    check(64'(irq), {63'h0, s[20]});
    rd(C0, 64'h0);
  endtask

  task automatic t_misc;
    logic [3:0] q [4] = '{4'h0, 4'h4, 4'hb, 4'hf};
    l2_state_in = 4'h4;
    foreach (q[i]) begin
      arm({16'h0043, 4'h0, q[i], 8'h29});
      pulse(2);
      rd(C0, (q[i] & l2_state_in) != 4'h0 ? 64'h2 : 64'h0);
    end
    // Only the any-agent flag pulses: self mode must stay at zero
    for (int a = 0; a < 2; a++) begin
      arm({16'h0043, 2'h0, a[0], 5'h0, 8'h70});
      rc = 2'h2;
      repeat (3) @(negedge core_clk_in);
      rc = 2'h0;
      rd(C0, 64'(3 * a));
    end
    halted_in = 1'b1;
    arm(32'h0043_0079);
    rd(C0, 64'h0);
    halted_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    halted_in = 1'b1;
    rd(C0, 64'h3);
  endtask

  initial begin
    repeat (2) @(negedge core_clk_in);
    rstn_in = 1'b1;
    @(negedge core_clk_in);
    t_regs();
    t_codes();
    t_priv(32'h0042_00c0, 2'h3, 2'h0);
    t_priv(32'h0041_00c0, 2'h0, 2'h2);
    t_priv(32'h0003_00c0, 2'h3, 2'h0);
    t_thresh();
    t_ovf(32'h004b_00c0);
    t_ovf(32'h0053_00c0);
    t_misc();
    complete_run();
  end
endmodule
